// *** rtl/dmsm_core.v ***
/*
 data memory segment mapper: pointer registers, stack pointer, segment
 register, extended RAM, 8-bit alu, program counter and program memory.
 assumes one core clock, a core that issues one request per cycle,
 and a software port with read data one cycle after the read strobe.
*/
`timescale 1ns/1ps
`include "dmsm_map.vh"
module dmsm_core (
  input  wire        core_clk,
  input  wire        resetn,
  input  wire [7:0]  sw_addr,
  input  wire [7:0]  sw_wdata,
  input  wire        sw_wr,
  input  wire        sw_rd,
  output reg  [7:0]  sw_rdata,
  input  wire        acc_valid,
  input  wire [1:0]  acc_src,
  input  wire [7:0]  acc_addr,
  input  wire [2:0]  acc_op,
  input  wire [2:0]  acc_bit,
  input  wire [1:0]  acc_post,
  input  wire [7:0]  acc_wdata,
  output reg         acc_done,
  output reg  [7:0]  acc_rdata,
  output reg  [15:0] acc_ext_addr,
  output reg         acc_bit_val,
  output reg         acc_skip,
  output reg         acc_no_ram,
  output reg         acc_periph,
  input  wire        alu_valid,
  input  wire [2:0]  alu_op,
  input  wire [7:0]  alu_a,
  input  wire [7:0]  alu_b,
  input  wire        alu_cin,
  output reg         alu_done,
  output reg  [7:0]  alu_result,
  output reg         alu_cout,
  input  wire [2:0]  pc_cmd,
  input  wire [14:0] pc_target,
  output reg  [14:0] program_counter,
  output reg  [7:0]  fetch_data,
  input  wire        prog_wr,
  input  wire        prog_erase,
  input  wire [14:0] prog_addr,
  input  wire [7:0]  prog_wdata,
  output reg         prog_busy
);

  reg  [1:0]  rst_sync;
  wire        rst_n = rst_sync[1];
  reg  [7:0]  alternate_ram_pointer;
  reg  [7:0]  primary_ram_pointer;
  reg  [7:0]  stack_top_pointer;
  reg  [7:0]  page_extend_reg;
  reg  [7:0]  data_ram [0:1023];
  reg  [7:0]  prog_mem [0:`DMSM_PROG_DEPTH-1];
  reg  [14:0] erase_addr;
  reg  [7:0]  base_addr;
  reg  [7:0]  seg_sel;
  reg  [15:0] ext_addr;
  reg  [1:0]  region;
  reg  [9:0]  ram_idx;
  reg  [7:0]  cur_data;
  reg  [7:0]  bit_mask;
  reg  [7:0]  next_data;
  reg         do_store;
  reg  [8:0]  alu_full;

  wire [6:0] counter_upper_part = program_counter[14:8];
  wire [7:0] counter_lower_part = program_counter[7:0];

  // segment extension of a single-byte address
  function [15:0] extend;
    input [7:0] a;
    input [7:0] seg;
    begin
      if (a[7])
        extend = {8'h00, a};
      else
        extend = {seg, 1'b0, a[6:0]};
    end
  endfunction

  // what sits behind an extended address
  function [1:0] region_of;
    input [15:0] e;
    begin
      if (e[15:8] == 8'h00 && e[7])
      begin
        if (e[7:0] >= `DMSM_PTR_BASE)
          region_of = `DMSM_RG_PTR;
        else if (e[7:0] >= `DMSM_REGS_BASE)
          region_of = `DMSM_RG_RAM;
        else
          region_of = `DMSM_RG_PERI;
      end
      else if (e[15:8] == 8'h00)
        region_of = (e[6:0] > `DMSM_LOW_RAM_END) ? `DMSM_RG_NONE
                                                 : `DMSM_RG_RAM;
      else if (e[15:8] < `DMSM_EXT_SEG_MAX)
        region_of = `DMSM_RG_RAM;
      else if (e[15:8] == `DMSM_EXT_SEG_MAX)
        region_of = (e[6:0] > `DMSM_SEG7_LAST) ? `DMSM_RG_NONE
                                               : `DMSM_RG_RAM;
      else
        region_of = `DMSM_RG_NONE;
    end
  endfunction

  // packs the RAM windows into one dense array
  function [9:0] index_of;
    input [15:0] e;
    begin
      if (e[15:8] == 8'h00)
        index_of = e[7] ? (`DMSM_REGS_IDX + {6'h00, e[3:0]})
                        : {3'h0, e[6:0]};
      else
        // segment s window starts at s * 128, above the segment zero bytes
        index_of = {e[10:8], e[6:0]};
    end
  endfunction

  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end

  // address path
  always @*
  begin
    case (acc_src)
      `DMSM_SRC_PRIM:  base_addr = primary_ram_pointer;
      `DMSM_SRC_ALT:   base_addr = alternate_ram_pointer;
      `DMSM_SRC_STACK: base_addr = (acc_post == `DMSM_POST_INC)
                                   ? stack_top_pointer + 8'h01
                                   : stack_top_pointer;
      default:         base_addr = acc_addr;
    endcase
    seg_sel  = (acc_src == `DMSM_SRC_STACK) ? 8'h00 : page_extend_reg;
    ext_addr = extend(base_addr, seg_sel);
    region   = region_of(ext_addr);
    ram_idx  = index_of(ext_addr);
    bit_mask = 8'h01 << acc_bit;
    case (region)
      `DMSM_RG_RAM: cur_data = data_ram[ram_idx];
      `DMSM_RG_PTR:
      begin
        case (ext_addr[1:0])
          2'h0:    cur_data = alternate_ram_pointer;
          2'h1:    cur_data = stack_top_pointer;
          2'h2:    cur_data = primary_ram_pointer;
          default: cur_data = page_extend_reg;
        endcase
      end
      default: cur_data = 8'h00;
    endcase
    do_store = acc_valid;
    case (acc_op)
      `DMSM_OP_WRITE: next_data = acc_wdata;
      `DMSM_OP_SET:   next_data = cur_data | bit_mask;
      `DMSM_OP_CLR:   next_data = cur_data & ~bit_mask;
      `DMSM_OP_DSZ:   next_data = cur_data - 8'h01;
      default:
      begin
        next_data = cur_data;
        do_store  = 1'b0;
      end
    endcase
    // decrement-and-skip only applies to the sixteen register bytes
    if (acc_op == `DMSM_OP_DSZ &&
        (ext_addr[15:8] != 8'h00 || ext_addr[7:0] < `DMSM_REGS_BASE))
      do_store = 1'b0;
  end

  // data RAM has no reset; contents are undefined after power-up
  always @(posedge core_clk)
  begin
    if (do_store && region == `DMSM_RG_RAM)
      data_ram[ram_idx] <= next_data;
  end

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_done     <= 1'b0;
      acc_rdata    <= 8'h00;
      acc_ext_addr <= 16'h0000;
      acc_bit_val  <= 1'b0;
      acc_skip     <= 1'b0;
      acc_no_ram   <= 1'b0;
      acc_periph   <= 1'b0;
    end
    else
    begin
      acc_done <= acc_valid;
      if (acc_valid)
      begin
        acc_rdata    <= (acc_op == `DMSM_OP_DSZ && do_store) ? next_data
                                                             : cur_data;
        acc_ext_addr <= ext_addr;
        acc_bit_val  <= |(cur_data & bit_mask);
        acc_skip     <= do_store && acc_op == `DMSM_OP_DSZ &&
                        next_data == 8'h00;
        acc_no_ram   <= region == `DMSM_RG_NONE;
        acc_periph   <= region == `DMSM_RG_PERI;
      end
    end
  end

  // pointer registers; the core's access wins over the software port,
  // and post-adjust of the pointer in use wins over both
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      alternate_ram_pointer <= 8'h00;
      primary_ram_pointer   <= 8'h00;
      stack_top_pointer     <= `DMSM_SP_RST;
      page_extend_reg       <= 8'h00;
    end
    else
    begin
      if (sw_wr)
      begin
        case (sw_addr)
          `DMSM_OFF_ALT:  alternate_ram_pointer <= sw_wdata;
          `DMSM_OFF_SP:   stack_top_pointer     <= sw_wdata;
          `DMSM_OFF_PRIM: primary_ram_pointer   <= sw_wdata;
          `DMSM_OFF_SEG:  page_extend_reg       <= sw_wdata;
          default:        ;
        endcase
      end
      if (do_store && region == `DMSM_RG_PTR)
      begin
        case (ext_addr[1:0])
          2'h0:    alternate_ram_pointer <= next_data;
          2'h1:    stack_top_pointer     <= next_data;
          2'h2:    primary_ram_pointer   <= next_data;
          default: page_extend_reg       <= next_data;
        endcase
      end
      if (acc_valid)
      begin
        case (acc_src)
          `DMSM_SRC_PRIM:
          begin
            if (acc_post == `DMSM_POST_INC)
              primary_ram_pointer <= primary_ram_pointer + 8'h01;
            else if (acc_post == `DMSM_POST_DEC)
              primary_ram_pointer <= primary_ram_pointer - 8'h01;
          end
          `DMSM_SRC_ALT:
          begin
            if (acc_post == `DMSM_POST_INC)
              alternate_ram_pointer <= alternate_ram_pointer + 8'h01;
            else if (acc_post == `DMSM_POST_DEC)
              alternate_ram_pointer <= alternate_ram_pointer - 8'h01;
          end
          `DMSM_SRC_STACK:
          begin
            if (acc_post == `DMSM_POST_INC)
              stack_top_pointer <= stack_top_pointer + 8'h01;
            else if (acc_post == `DMSM_POST_DEC)
              stack_top_pointer <= stack_top_pointer - 8'h01;
          end
          default: ;
        endcase
      end
    end
  end

  // alu
  always @*
  begin
    case (alu_op)
      `DMSM_ALU_ADD: alu_full = {1'b0, alu_a} + {1'b0, alu_b} +
                                {8'h00, alu_cin};
      `DMSM_ALU_SUB: alu_full = {1'b0, alu_a} - {1'b0, alu_b};
      `DMSM_ALU_AND: alu_full = {1'b0, alu_a & alu_b};
      `DMSM_ALU_OR:  alu_full = {1'b0, alu_a | alu_b};
      `DMSM_ALU_XOR: alu_full = {1'b0, alu_a ^ alu_b};
      `DMSM_ALU_SHL: alu_full = {alu_a, alu_cin};
      `DMSM_ALU_SHR: alu_full = {alu_a[0], alu_cin, alu_a[7:1]};
      default:       alu_full = {1'b0, alu_a};
    endcase
  end

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      alu_done   <= 1'b0;
      alu_result <= 8'h00;
      alu_cout   <= 1'b0;
    end
    else
    begin
      alu_done <= alu_valid;
      if (alu_valid)
      begin
        alu_result <= alu_full[7:0];
        alu_cout   <= (alu_op == `DMSM_ALU_SUB) ? ~alu_full[8] : alu_full[8];
      end
    end
  end

  // program counter and fetch
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      program_counter <= `DMSM_PC_RST;
      fetch_data      <= `DMSM_TRAP_OP;
    end
    else
    begin
      case (pc_cmd)
        `DMSM_PC_STEP: program_counter <= program_counter + 15'h0001;
        `DMSM_PC_JUMP: program_counter <= pc_target;
        `DMSM_PC_RET:
          program_counter <= (stack_top_pointer == `DMSM_SP_RST)
                             ? `DMSM_PC_TOP : pc_target;
        `DMSM_PC_VEC:  program_counter <= `DMSM_VECTOR;
        default:       ;
      endcase
      // the top location always fetches the trap opcode
      fetch_data <= (program_counter == `DMSM_PC_TOP) ? `DMSM_TRAP_OP
                                                      : prog_mem[program_counter];
    end
  end

  // page erase walks one byte a cycle; writes are refused while busy
  always @(posedge core_clk)
  begin
    if (prog_busy)
      prog_mem[erase_addr] <= `DMSM_ERASED;
    else if (prog_wr)
      prog_mem[prog_addr] <= prog_wdata;
  end

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prog_busy  <= 1'b0;
      erase_addr <= 15'h0000;
    end
    else if (prog_busy)
    begin
      erase_addr <= erase_addr + 15'h0001;
      if (erase_addr[6:0] == `DMSM_PAGE_LAST)
        prog_busy <= 1'b0;
    end
    else if (prog_erase)
    begin
      prog_busy  <= 1'b1;
      erase_addr <= {prog_addr[14:7], 7'h00};
    end
  end

  // software read port
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      sw_rdata <= 8'h00;
    else if (sw_rd)
    begin
      case (sw_addr)
        `DMSM_OFF_STATUS: sw_rdata <= {7'h00, prog_busy};
        `DMSM_OFF_PC_LO:  sw_rdata <= counter_lower_part;
        `DMSM_OFF_PC_HI:  sw_rdata <= {1'b0, counter_upper_part};
        `DMSM_OFF_ALT:    sw_rdata <= alternate_ram_pointer;
        `DMSM_OFF_SP:     sw_rdata <= stack_top_pointer;
        `DMSM_OFF_PRIM:   sw_rdata <= primary_ram_pointer;
        `DMSM_OFF_SEG:    sw_rdata <= page_extend_reg;
        default:          sw_rdata <= 8'h00;
      endcase
    end
    else
      sw_rdata <= 8'h00;
  end

endmodule // dmsm_core

// *** rtl/dmsm_map.vh ***
/*
 constant map of the data memory segment mapper: register offsets,
 address regions, reset values and operation codes.
 assumes it is included once by bare name from the mapper core.
*/
`ifndef DMSM_MAP_VH
`define DMSM_MAP_VH
// software port offsets
`define DMSM_OFF_STATUS  8'h00
`define DMSM_OFF_PC_LO   8'h01
`define DMSM_OFF_PC_HI   8'h02
`define DMSM_OFF_ALT     8'hFC
`define DMSM_OFF_SP      8'hFD
`define DMSM_OFF_PRIM    8'hFE
`define DMSM_OFF_SEG     8'hFF
// reset values, fixed program addresses and fixed data bytes
`define DMSM_SP_RST      8'h6F
`define DMSM_PC_RST      15'h0000
`define DMSM_PC_TOP      15'h7FFF
`define DMSM_VECTOR      15'h00FF
`define DMSM_TRAP_OP     8'h00
`define DMSM_ERASED      8'h00
// data map
`define DMSM_REGS_BASE   8'hF0
`define DMSM_PTR_BASE    8'hFC
`define DMSM_LOW_RAM_END 7'h6F
`define DMSM_EXT_SEG_MAX 8'h07
`define DMSM_SEG7_LAST   7'h7B
`define DMSM_REGS_IDX    10'h070
`define DMSM_EXT_IDX     10'h080
// regions
`define DMSM_RG_RAM      2'h0
`define DMSM_RG_NONE     2'h1
`define DMSM_RG_PERI     2'h2
`define DMSM_RG_PTR      2'h3
// address sources
`define DMSM_SRC_DIR     2'h0
`define DMSM_SRC_PRIM    2'h1
`define DMSM_SRC_ALT     2'h2
`define DMSM_SRC_STACK   2'h3
// post modes: pointer inc/dec, stack pop (pre-inc) / push (post-dec)
`define DMSM_POST_NONE   2'h0
`define DMSM_POST_INC    2'h1
`define DMSM_POST_DEC    2'h2
// data operations
`define DMSM_OP_READ     3'h0
`define DMSM_OP_WRITE    3'h1
`define DMSM_OP_SET      3'h2
`define DMSM_OP_CLR      3'h3
`define DMSM_OP_TEST     3'h4
`define DMSM_OP_DSZ      3'h5
// alu operations
`define DMSM_ALU_ADD     3'h0
`define DMSM_ALU_SUB     3'h1
`define DMSM_ALU_AND     3'h2
`define DMSM_ALU_OR      3'h3
`define DMSM_ALU_XOR     3'h4
`define DMSM_ALU_SHL     3'h5
`define DMSM_ALU_SHR     3'h6
// program counter commands
`define DMSM_PC_HOLD     3'h0
`define DMSM_PC_STEP     3'h1
`define DMSM_PC_JUMP     3'h2
`define DMSM_PC_RET      3'h3
`define DMSM_PC_VEC      3'h4
// program memory
`define DMSM_PROG_DEPTH  32768
`define DMSM_PAGE_LAST   7'h7F
`endif

// *** testbench/dmsm_core_asserts.sv ***
/*
 checker on the mapper core ports, bound into every core instance.
 assumes rising core_clk sampling and active-low resetn.
*/
`timescale 1ns/1ps
module dmsm_core_asserts (
  input logic        core_clk,
  input logic        resetn,
  input logic        acc_valid,
  input logic [1:0]  acc_src,
  input logic [7:0]  acc_addr,
  input logic        acc_done,
  input logic [15:0] acc_ext_addr,
  input logic        acc_no_ram,
  input logic        acc_periph,
  input logic        alu_valid,
  input logic [2:0]  alu_op,
  input logic [7:0]  alu_a,
  input logic [7:0]  alu_b,
  input logic        alu_cin,
  input logic        alu_done,
  input logic [7:0]  alu_result,
  input logic        alu_cout,
  input logic [2:0]  pc_cmd,
  input logic [14:0] program_counter,
  input logic [7:0]  fetch_data,
  input logic        prog_erase,
  input logic        prog_busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  property p_up;
    acc_valid && acc_src == 2'h0 && acc_addr[7] |=> acc_ext_addr == {8'h00, $past(acc_addr)};
  endproperty
  a_up: assert property (p_up) else $error("upper address extended");
  property p_stk;
    acc_valid && acc_src == 2'h3 |=> acc_done && acc_ext_addr[15:8] == 8'h00;
  endproperty
  a_stk: assert property (p_stk) else $error("stack left segment zero");
  property p_nram;
    acc_done && acc_ext_addr[15:4] == 12'h007 |-> acc_no_ram;
  endproperty
  a_nram: assert property (p_nram) else $error("ram seen at 70..7F");
  property p_peri;
    acc_done && acc_ext_addr inside {[16'h0080:16'h00EF]} |-> acc_periph;
  endproperty
  a_peri: assert property (p_peri) else $error("peripheral space missed");
  property p_add;
    alu_valid && alu_op == 3'h0 && !alu_cin
      |=> alu_done && {alu_cout, alu_result} == $past(alu_a) + $past(alu_b);
  endproperty
  a_add: assert property (p_add) else $error("add wrong or late");
  property p_vec;
    pc_cmd == 3'h4 |=> program_counter == 15'h00FF;
  endproperty
  a_vec: assert property (p_vec) else $error("vector address wrong");
  property p_trap;
    program_counter == 15'h7FFF |=> fetch_data == 8'h00;
  endproperty
  a_trap: assert property (p_trap) else $error("top fetch not zero");
  property p_page;
    prog_erase && !prog_busy |=> prog_busy [*8];
  endproperty
  a_page: assert property (p_page) else $error("erase busy dropped");
endmodule // dmsm_core_asserts
bind dmsm_core dmsm_core_asserts u_chk (.core_clk, .resetn, .acc_valid, .acc_src,
  .acc_addr, .acc_done, .acc_ext_addr, .acc_no_ram, .acc_periph, .alu_valid, .alu_op,
  .alu_a, .alu_b, .alu_cin, .alu_done, .alu_result, .alu_cout, .pc_cmd,
  .program_counter, .fetch_data, .prog_erase, .prog_busy);

// *** testbench/dmsm_core_test.sv ***
/*
 self-checking bench for the segment mapper core, one task per scenario.
 assumes the request model beside the core and the bound checker.
*/
`timescale 1ns/1ps
module dmsm_core_test;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  sw_addr = 8'h00, sw_wdata = 8'h00, prog_wdata = 8'h00;
  logic        sw_wr = 1'b0, sw_rd = 1'b0, prog_wr = 1'b0, prog_erase = 1'b0;
  logic [2:0]  pc_cmd = 3'h0;
  logic [14:0] pc_target = 15'h0000, prog_addr = 15'h0000;
  wire  [7:0]  sw_rdata, acc_addr, acc_wdata, acc_rdata, alu_a, alu_b, alu_result;
  wire  [7:0]  fetch_data;
  wire  [1:0]  acc_src, acc_post;
  wire  [2:0]  acc_op, acc_bit, alu_op;
  wire  [15:0] acc_ext_addr;
  wire  [14:0] program_counter;
  wire         acc_valid, acc_done, acc_bit_val, acc_skip, acc_no_ram, acc_periph;
  wire         alu_valid, alu_cin, alu_done, alu_cout, prog_busy;
  int          errors = 0, compares = 0;
  dmsm_core DUT (.core_clk, .resetn, .sw_addr, .sw_wdata, .sw_wr, .sw_rd, .sw_rdata,
    .acc_valid, .acc_src, .acc_addr, .acc_op, .acc_bit, .acc_post, .acc_wdata, .acc_done,
    .acc_rdata, .acc_ext_addr, .acc_bit_val, .acc_skip, .acc_no_ram, .acc_periph,
    .alu_valid, .alu_op, .alu_a, .alu_b, .alu_cin, .alu_done, .alu_result, .alu_cout,
    .pc_cmd, .pc_target, .program_counter, .fetch_data, .prog_wr, .prog_erase,
    .prog_addr, .prog_wdata, .prog_busy);
  dmsm_exec_model u_cpu (.core_clk, .acc_valid, .acc_src, .acc_addr, .acc_op, .acc_bit,
    .acc_post, .acc_wdata, .alu_valid, .alu_op, .alu_a, .alu_b, .alu_cin);
  initial forever #25 core_clk = ~core_clk;
  task automatic stop_test();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic sw_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge core_clk);
    sw_wr <= 1'b0;
  endtask
  task automatic sw_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge core_clk);
    sw_rd <= 1'b0;
    #1;
    chk(sw_rdata, e);
  endtask
  task automatic pc_do(input logic [2:0] c, input logic [14:0] t);
    @(posedge core_clk);
    pc_cmd <= c;
    pc_target <= t;
    @(posedge core_clk);
    pc_cmd <= 3'h0;
    #1;
  endtask
  task automatic alu_chk(input logic [2:0] o, input logic [7:0] a, input logic [7:0] b,
                         input logic [8:0] m, input logic [8:0] e);
    u_cpu.alu(o, a, b);
    chk(alu_done, 16'h0001);
    chk({alu_cout, alu_result} & m, e);
  endtask
  task automatic t_reset();
    #1;
    chk(program_counter, 16'h0000);
    sw_chk(8'hFD, 8'h6F);
    sw_chk(8'hFF, 8'h00);
    sw_chk(8'h40, 8'h00);
  endtask
  task automatic t_seg();
    sw_write(8'hFF, 8'h03);
    u_cpu.acc(2'h0, 8'h10, 3'h1, 3'h0, 2'h0, 8'hA5);
    chk(acc_ext_addr, 16'h0310);
    u_cpu.acc(2'h0, 8'h10, 3'h0, 3'h0, 2'h0, 8'h00);
    chk(acc_rdata, 16'h00A5);
    u_cpu.acc(2'h0, 8'h95, 3'h0, 3'h0, 2'h0, 8'h00);
    chk(acc_ext_addr, 16'h0095);
    chk(acc_periph, 16'h0001);
    sw_write(8'hFF, 8'h04);
    u_cpu.acc(2'h0, 8'h10, 3'h1, 3'h0, 2'h0, 8'h4C);
    sw_write(8'hFF, 8'h00);
    u_cpu.acc(2'h0, 8'h10, 3'h1, 3'h0, 2'h0, 8'h0C);
    sw_write(8'hFF, 8'h04);
    u_cpu.acc(2'h0, 8'h10, 3'h0, 3'h0, 2'h0, 8'h00);
    chk(acc_rdata, 16'h004C);
    sw_write(8'hFF, 8'h07);
    u_cpu.acc(2'h0, 8'h7C, 3'h1, 3'h0, 2'h0, 8'h00);
    chk(acc_no_ram, 16'h0001);
    sw_write(8'hFF, 8'h00);
    u_cpu.acc(2'h0, 8'h70, 3'h1, 3'h0, 2'h0, 8'h5A);
    u_cpu.acc(2'h0, 8'h70, 3'h0, 3'h0, 2'h0, 8'h00);
    chk(acc_rdata, 16'h0000);
  endtask
  task automatic t_stack();
    sw_write(8'hFF, 8'h05);
    u_cpu.acc(2'h3, 8'h00, 3'h1, 3'h0, 2'h2, 8'h5A);
    chk(acc_ext_addr, 16'h006F);
    sw_chk(8'hFD, 8'h6E);
    sw_chk(8'hFF, 8'h05);
    u_cpu.acc(2'h3, 8'h00, 3'h0, 3'h0, 2'h1, 8'h00);
    chk(acc_rdata, 16'h005A);
    sw_chk(8'hFD, 8'h6F);
  endtask
  task automatic t_ptr();
    sw_write(8'hFE, 8'h20);
    sw_write(8'hFC, 8'h31);
    u_cpu.acc(2'h1, 8'h00, 3'h1, 3'h0, 2'h1, 8'h3C);
    chk(acc_ext_addr, 16'h0520);
    u_cpu.acc(2'h2, 8'h00, 3'h1, 3'h0, 2'h2, 8'h3D);
    chk(acc_ext_addr, 16'h0531);
    sw_chk(8'hFE, 8'h21);
    sw_chk(8'hFC, 8'h30);
  endtask
  task automatic t_reg();
    u_cpu.acc(2'h0, 8'hF5, 3'h1, 3'h0, 2'h0, 8'h01);
    u_cpu.acc(2'h0, 8'hF5, 3'h5, 3'h0, 2'h0, 8'h00);
    chk(acc_skip, 16'h0001);
    chk(acc_rdata, 16'h0000);
    u_cpu.acc(2'h0, 8'h10, 3'h5, 3'h0, 2'h0, 8'h00);
    chk(acc_skip, 16'h0000);
    u_cpu.acc(2'h0, 8'hF5, 3'h2, 3'h3, 2'h0, 8'h00);
    u_cpu.acc(2'h0, 8'hF5, 3'h4, 3'h3, 2'h0, 8'h00);
    chk(acc_bit_val, 16'h0001);
    u_cpu.acc(2'h0, 8'hF5, 3'h3, 3'h3, 2'h0, 8'h00);
    u_cpu.acc(2'h0, 8'hF5, 3'h0, 3'h0, 2'h0, 8'h00);
    chk(acc_rdata, 16'h0000);
  endtask
  task automatic t_alu();
    alu_chk(3'h0, 8'hFF, 8'h01, 9'h1FF, 9'h100);
    alu_chk(3'h1, 8'h05, 8'h03, 9'h1FF, 9'h102);
    alu_chk(3'h2, 8'hF0, 8'h3C, 9'h1FF, 9'h030);
    alu_chk(3'h3, 8'hF0, 8'h0C, 9'h1FF, 9'h0FC);
    alu_chk(3'h4, 8'hFF, 8'h0F, 9'h1FF, 9'h0F0);
    alu_chk(3'h5, 8'h81, 8'h00, 9'h1FF, 9'h102);
    alu_chk(3'h6, 8'h81, 8'h00, 9'h1FF, 9'h140);
  endtask
  task automatic t_pc();
    pc_do(3'h4, 15'h0000);
    chk(program_counter, 16'h00FF);
    pc_do(3'h3, 15'h0123);
    chk(program_counter, 16'h7FFF);
    @(posedge core_clk);
    #1;
    chk(fetch_data, 16'h0000);
    pc_do(3'h1, 15'h0000);
    chk(program_counter, 16'h0000);
    u_cpu.acc(2'h3, 8'h00, 3'h1, 3'h0, 2'h2, 8'h11);
    pc_do(3'h3, 15'h0123);
    chk(program_counter, 16'h0123);
    sw_chk(8'h01, 8'h23);
    sw_chk(8'h02, 8'h01);
  endtask
  task automatic t_prog();
    int n;
    @(posedge core_clk);
    prog_addr <= 15'h0105;
    prog_wdata <= 8'hA7;
    prog_wr <= 1'b1;
    @(posedge core_clk);
    prog_wr <= 1'b0;
    pc_do(3'h2, 15'h0105);
    @(posedge core_clk);
    #1;
    chk(fetch_data, 16'h00A7);
    @(posedge core_clk);
    prog_addr <= 15'h0100;
    prog_erase <= 1'b1;
    @(posedge core_clk);
    prog_erase <= 1'b0;
    #1;
    n = 0;
    while (prog_busy === 1'b1 && n < 300)
    begin
      n++;
      @(posedge core_clk);
      #1;
    end
    chk(n, 16'h0080);
    pc_do(3'h2, 15'h0105);
    @(posedge core_clk);
    #1;
    chk(fetch_data, 16'h0000);
  endtask
  initial
  begin
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_reset();
    t_seg();
    t_stack();
    t_ptr();
    t_reg();
    t_alu();
    t_pc();
    t_prog();
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_reset();
    stop_test();
  end
  // whole sequence runs well under a thousand cycles
  initial
  begin
    #(50 * 4000);
    errors++;
    stop_test();
  end
endmodule // dmsm_core_test

// *** testbench/dmsm_exec_model.sv ***
/*
 core-side request model: issues data accesses and alu operations.
 assumes each call starts at a fresh rising edge of core_clk.
*/
`timescale 1ns/1ps
module dmsm_exec_model (
  input  logic       core_clk,
  output logic       acc_valid,
  output logic [1:0] acc_src,
  output logic [7:0] acc_addr,
  output logic [2:0] acc_op,
  output logic [2:0] acc_bit,
  output logic [1:0] acc_post,
  output logic [7:0] acc_wdata,
  output logic       alu_valid,
  output logic [2:0] alu_op,
  output logic [7:0] alu_a,
  output logic [7:0] alu_b,
  output logic       alu_cin
);
  initial {acc_valid, acc_src, acc_addr, acc_op, acc_bit, acc_post, acc_wdata} = '0;
  initial {alu_valid, alu_op, alu_a, alu_b, alu_cin} = '0;
  // address, write data and alu_a flip once valid drops so a core that ignores valid is seen
  task automatic acc(input logic [1:0] s, input logic [7:0] a, input logic [2:0] o,
                     input logic [2:0] b, input logic [1:0] p, input logic [7:0] d);
    @(posedge core_clk);
    acc_valid <= 1'b1;
    {acc_src, acc_addr, acc_op, acc_bit, acc_post, acc_wdata} <= {s, a, o, b, p, d};
    @(posedge core_clk);
    acc_valid <= 1'b0;
    acc_addr <= ~a;
    acc_wdata <= ~d;
    #1;
  endtask
  task automatic alu(input logic [2:0] o, input logic [7:0] a, input logic [7:0] b);
    @(posedge core_clk);
    alu_valid <= 1'b1;
    {alu_op, alu_a, alu_b, alu_cin} <= {o, a, b, 1'b0};
    @(posedge core_clk);
    alu_valid <= 1'b0;
    alu_a <= ~a;
    #1;
  endtask
endmodule // dmsm_exec_model
